// >>> rtl/pbs_sram.sv
// pipelined burst sram core: strobes, chip selects, byte writes, sleep
`timescale 1ns/10ps
`default_nettype none
module pbs_sram (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [pbs_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_processor_strobe_n,
  input wire logic i_controller_strobe_n,
  input wire logic i_burst_step_n,
  input wire logic i_global_write_n,
  input wire logic i_byte_write_gate_n,
  input wire logic [pbs_pkg::LANES-1:0] i_byte_lane_select_n,
  input wire logic i_chip_select_a_n,
  input wire logic i_chip_select_b,
  input wire logic i_chip_select_c_n,
  input wire logic i_output_drive_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_order,
  input wire logic [pbs_pkg::DATA_W-1:0] i_dq,
  output logic [pbs_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_sleep_active
);
  import pbs_pkg::*;

  // storage array, one row per byte lane, not reset
  logic [BYTE_W-1:0] mem [LANES][WORDS];

  // asynchronous pins through two flops
  logic [SYNC_W-1:0] sleep_sync_q;
  logic [SYNC_W-1:0] drive_sync_q;
  logic [SYNC_W-1:0] order_sync_q;
  logic sleep_w;
  logic drive_n_w;

  // decode of the sampled pins
  logic selected;
  logic proc_start;
  logic ctrl_start;
  logic start;
  logic deselect;
  logic cont;
  logic [LANES-1:0] lanes;
  logic wr_req;
  pbs_op_t op_d;

  // captured access
  pbs_op_t op_q;
  logic [ADDR_W-1:0] acc_addr_q;
  logic [HI_W-1:0] addr_hi_q;
  logic [DATA_W-1:0] din_q;
  logic [LANES-1:0] lanes_q;
  logic active_q;
  logic fresh_q;

  // output side
  logic [DATA_W-1:0] dout_q;
  logic rd_out_q;
  logic rd_out_d;

  pbs_burst_if bif ();

  function automatic logic chip_on(
    input logic a_n,
    input logic b,
    input logic c_n
  );
    chip_on = ~a_n & b & ~c_n;
  endfunction : chip_on

  function automatic logic [LANES-1:0] lane_mask(
    input logic gw_n,
    input logic bwe_n,
    input logic [LANES-1:0] bw_n
  );
    if (!gw_n)
    begin
      lane_mask = LANES_ALL;
    end
    else if (!bwe_n)
    begin
      lane_mask = ~bw_n;
    end
    else
    begin
      lane_mask = LANES_NONE;
    end
  endfunction : lane_mask

  // sleep request synchroniser sets entry and exit delay
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sleep_sync_q <= SYNC_LOW;
    end
    else
    begin
      sleep_sync_q <= {sleep_sync_q[0], i_sleep_request};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      drive_sync_q <= SYNC_HIGH;
    end
    else
    begin
      drive_sync_q <= {drive_sync_q[0], i_output_drive_n};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      order_sync_q <= SYNC_HIGH;
    end
    else
    begin
      order_sync_q <= {order_sync_q[0], i_burst_order};
    end
  end

  assign sleep_w = sleep_sync_q[SYNC_W-1];
  assign drive_n_w = drive_sync_q[SYNC_W-1];
  assign o_sleep_active = sleep_w;

  // access decode
  always_comb
  begin
    selected = chip_on(i_chip_select_a_n, i_chip_select_b, i_chip_select_c_n);
    proc_start = ~i_processor_strobe_n & ~i_chip_select_a_n;
    ctrl_start = ~i_controller_strobe_n & ~proc_start;
    start = (proc_start | ctrl_start) & selected & ~sleep_w;
    deselect = (proc_start | ~i_controller_strobe_n) & ~selected;
    cont = ~proc_start & i_controller_strobe_n & active_q & ~sleep_w;
    lanes = lane_mask(i_global_write_n, i_byte_write_gate_n, i_byte_lane_select_n);
    wr_req = |lanes;
  end

  always_comb
  begin
    op_d = OP_NONE;
    if (start && proc_start)
    begin
      op_d = OP_READ;
    end
    else if (start)
    begin
      op_d = wr_req ? OP_WRITE : OP_READ;
    end
    else if (cont)
    begin
      op_d = wr_req ? OP_WRITE : OP_READ;
    end
  end

  // burst counter control
  assign bif.load = start;
  assign bif.step = cont & ~i_burst_step_n;
  assign bif.linear = (order_sync_q[SYNC_W-1] == ORDER_LINEAR);
  assign bif.start_bits = i_addr[BURST_W-1:0];

  pbs_burst_ctr u_burst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .bi(bif)
  );

  // selection state
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      active_q <= 1'b0;
    end
    else if (sleep_w)
    begin
      active_q <= 1'b0;
    end
    else if (start)
    begin
      active_q <= 1'b1;
    end
    else if (deselect)
    begin
      active_q <= 1'b0;
    end
  end

  // high address bits, held through the burst
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      addr_hi_q <= '0;
    end
    else if (start)
    begin
      addr_hi_q <= i_addr[ADDR_W-1:BURST_W];
    end
  end

  // input registers for the access of this edge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      op_q <= OP_NONE;
      acc_addr_q <= '0;
      din_q <= '0;
      lanes_q <= LANES_NONE;
    end
    else
    begin
      op_q <= op_d;
      din_q <= i_dq;
      lanes_q <= (op_d == OP_WRITE) ? lanes : LANES_NONE;
      if (start)
      begin
        acc_addr_q <= {i_addr[ADDR_W-1:BURST_W], bif.nxt};
      end
      else
      begin
        acc_addr_q <= {addr_hi_q, bif.nxt};
      end
    end
  end

  // first cycle of an access, read or write, out of deselect
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      fresh_q <= 1'b0;
    end
    else
    begin
      fresh_q <= start & ~active_q;
    end
  end

  // self-timed write one edge after capture, dropped when sleep begins
  // each lane process owns its own array row and output register slice
  generate
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
      always_ff @(posedge i_clk)
      begin
        if (!i_rst && !sleep_w && op_q == OP_WRITE && lanes_q[g])
        begin
          mem[g][acc_addr_q] <= din_q[g*BYTE_W +: BYTE_W];
        end
      end

      // output register, one lane
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          dout_q[g*BYTE_W +: BYTE_W] <= '0;
        end
        else if (op_q == OP_READ)
        begin
          dout_q[g*BYTE_W +: BYTE_W] <= mem[g][acc_addr_q];
        end
      end
    end
  endgenerate

  // read data valid for driving; killed by deselect, write or sleep
  always_comb
  begin
    rd_out_d = (op_q == OP_READ) & ~sleep_w;
    if (deselect)
    begin
      rd_out_d = 1'b0;
    end
    if (op_d == OP_WRITE)
    begin
      rd_out_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rd_out_q <= 1'b0;
    end
    else
    begin
      rd_out_q <= rd_out_d;
    end
  end

  assign o_dq = dout_q;

  // drivers on only for read data, never in a write or first cycle
  always_comb
  begin
    o_dq_oe = rd_out_q & ~drive_n_w;
    if (fresh_q)
    begin
      o_dq_oe = 1'b0;
    end
    if (op_q == OP_WRITE)
    begin
      o_dq_oe = 1'b0;
    end
    if (sleep_w)
    begin
      o_dq_oe = 1'b0;
    end
  end
endmodule : pbs_sram
`default_nettype wire

// >>> rtl/pbs_pkg.sv
// shared constants and types for the pipelined burst sram
package pbs_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int LANES = 4;
  localparam int BURST_W = 2;
  localparam int HI_W = ADDR_W - BURST_W;
  localparam int WORDS = 1 << ADDR_W;
  localparam int SYNC_W = 2;
  localparam int CLK_PERIOD_PS = 4000;
  // sleep entry and recovery, in clock periods
  localparam int SLEEP_ENTRY_TCYC = 2;
  localparam int SLEEP_RECOVERY_TCYC = 2;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_TCYC;
  localparam int SLEEP_RECOVERY_CYC = SLEEP_RECOVERY_TCYC;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [SYNC_W-1:0] SYNC_LOW = 2'h0;
  localparam logic [SYNC_W-1:0] SYNC_HIGH = 2'h3;
  localparam logic ORDER_LINEAR = 1'b0;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } pbs_op_t;
endpackage : pbs_pkg

// >>> rtl/pbs_burst_if.sv
// burst counter control and address between sram core and counter
`timescale 1ns/10ps
`default_nettype none
interface pbs_burst_if;
  import pbs_pkg::*;
  logic load;
  logic step;
  logic linear;
  logic [BURST_W-1:0] start_bits;
  logic [BURST_W-1:0] nxt;
  modport ctr (input load, input step, input linear, input start_bits, output nxt);
  modport user (output load, output step, output linear, output start_bits, input nxt);
endinterface : pbs_burst_if
`default_nettype wire

// >>> rtl/pbs_burst_ctr.sv
// two-bit wraparound burst counter, interleaved or linear order
`timescale 1ns/10ps
`default_nettype none
module pbs_burst_ctr (
  input wire logic i_clk,
  input wire logic i_rst,
  pbs_burst_if.ctr bi
);
  import pbs_pkg::*;

  logic [BURST_W-1:0] start_q;
  logic [BURST_W-1:0] start_d;
  logic [BURST_W-1:0] cnt_q;
  logic [BURST_W-1:0] cnt_d;

  function automatic logic [BURST_W-1:0] order_bits(
    input logic [BURST_W-1:0] s,
    input logic [BURST_W-1:0] c,
    input logic lin
  );
    logic [BURST_W-1:0] sum;
    sum = s + c;
    if (lin)
    begin
      order_bits = sum;
    end
    else
    begin
      order_bits = s ^ c;
    end
  endfunction : order_bits

  always_comb
  begin
    start_d = start_q;
    cnt_d = cnt_q;
    if (bi.load)
    begin
      start_d = bi.start_bits;
      cnt_d = BURST_ZERO;
    end
    else if (bi.step)
    begin
      cnt_d = cnt_q + BURST_ONE;
    end
  end

  assign bi.nxt = order_bits(start_d, cnt_d, bi.linear);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      start_q <= BURST_ZERO;
      cnt_q <= BURST_ZERO;
    end
    else
    begin
      start_q <= start_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : pbs_burst_ctr
`default_nettype wire

// >>> sim/pbs_sram_monitor.sv
// concurrent checks on the pipelined burst sram ports
`timescale 1ns/10ps
`default_nettype none
module pbs_sram_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_processor_strobe_n,
  input wire logic i_controller_strobe_n,
  input wire logic i_global_write_n,
  input wire logic i_byte_write_gate_n,
  input wire logic [pbs_pkg::LANES-1:0] i_byte_lane_select_n,
  input wire logic i_chip_select_a_n,
  input wire logic i_chip_select_b,
  input wire logic i_chip_select_c_n,
  input wire logic i_output_drive_n,
  input wire logic i_sleep_request,
  input wire logic o_dq_oe,
  input wire logic o_sleep_active
);
  import pbs_pkg::*;
  logic sel, wr, rd_st, wr_c, dsel, zz;
  assign zz = o_sleep_active;
  assign sel = !i_chip_select_a_n && i_chip_select_b && !i_chip_select_c_n;
  assign wr = !i_global_write_n || (!i_byte_write_gate_n && i_byte_lane_select_n != LANES_ALL);
  assign rd_st = sel && !zz && (!i_processor_strobe_n || (!i_controller_strobe_n && !wr));
  assign wr_c = sel && !zz && i_processor_strobe_n && !i_controller_strobe_n && wr;
  assign dsel = !sel && !zz && (!i_controller_strobe_n || (!i_processor_strobe_n
    && !i_chip_select_a_n));
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  write_hiz_a: assert property (wr_c |=> !o_dq_oe)
    else $error("dq driven after a write");
  deselect_hiz_a: assert property (dsel |=> !o_dq_oe)
    else $error("dq driven after deselect");
  first_mask_a: assert property (dsel ##1 rd_st |=> !o_dq_oe)
    else $error("dq driven in first read cycle");
  read_drive_a: assert property ((rd_st && !i_output_drive_n) [*3] |=> o_dq_oe)
    else $error("dq not driven on back-to-back reads");
  drive_off_a: assert property (i_output_drive_n [*2] |=> !o_dq_oe)
    else $error("dq driven with output drive off");
  sleep_enter_a: assert property (i_sleep_request [*4] |-> zz)
    else $error("sleep not entered");
  sleep_exit_a: assert property (!i_sleep_request [*4] |-> !zz)
    else $error("sleep not left");
  sleep_lag_a: assert property ($rose(i_sleep_request) |-> !zz ##1 !zz)
    else $error("sleep entered too early");
  sleep_hiz_a: assert property (zz |-> !o_dq_oe)
    else $error("dq driven while asleep");
  cover property (rd_st ##1 rd_st ##1 rd_st);
  cover property (wr_c);
  cover property (zz);
endmodule : pbs_sram_monitor
`default_nettype wire

// >>> sim/pbs_host.sv
// bus master model driving strobes, selects and write data
`timescale 1ns/10ps
`default_nettype none
module pbs_host (
  input wire logic i_clk,
  output logic [pbs_pkg::ADDR_W-1:0] o_addr,
  output logic o_processor_strobe_n,
  output logic o_controller_strobe_n,
  output logic o_burst_step_n,
  output logic o_global_write_n,
  output logic o_byte_write_gate_n,
  output logic [pbs_pkg::LANES-1:0] o_byte_lane_select_n,
  output logic o_chip_select_a_n,
  output logic o_chip_select_b,
  output logic o_chip_select_c_n,
  output logic o_output_drive_n,
  output logic o_sleep_request,
  output logic o_burst_order,
  output logic [pbs_pkg::DATA_W-1:0] o_dq
);
  import pbs_pkg::*;
  logic [DATA_W-1:0] last = 32'h0;
  task automatic set(input logic zz, input logic ord);
    o_sleep_request = zz;
    o_burst_order = ord;
  endtask : set
  // one bus cycle; returns just after the edge that takes it
  task automatic put(input logic p, c, v, g, b, input logic [LANES-1:0] l, input logic s,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    o_processor_strobe_n = p;
    o_controller_strobe_n = c;
    o_burst_step_n = v;
    o_global_write_n = g;
    o_byte_write_gate_n = b;
    o_byte_lane_select_n = l;
    o_chip_select_a_n = !s;
    o_chip_select_b = s;
    o_chip_select_c_n = !s;
    o_addr = a;
    o_output_drive_n = !g || !b || !s;
    if (!g || !b)
      last = d;
    o_dq = (!g || !b) ? d : ~last;
    @(posedge i_clk);
    #1;
  endtask : put
  initial
  begin
    set(1'b0, 1'b1);
    put(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b0, 17'h0, 32'h0);
  end
endmodule : pbs_host
`default_nettype wire

// >>> sim/pipelined_burst_sram_bench.sv
// self-checking bench for the pipelined burst sram
`timescale 1ns/10ps
`default_nettype none
module pipelined_burst_sram_bench;
  import pbs_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr;
  logic i_processor_strobe_n, i_controller_strobe_n, i_burst_step_n, i_global_write_n;
  logic i_byte_write_gate_n, i_chip_select_a_n, i_chip_select_b, i_chip_select_c_n;
  logic i_output_drive_n, i_sleep_request, i_burst_order, o_dq_oe, o_sleep_active;
  logic [LANES-1:0] i_byte_lane_select_n;
  logic [DATA_W-1:0] i_dq, o_dq, h_dq;
  int miscompares = 0;
  int n_checks = 0;
  always #2 i_clk = ~i_clk;
  assign i_dq = o_dq_oe ? o_dq : h_dq;
  pbs_sram dut_u (.*);
  pbs_host host_u (.i_clk(i_clk), .o_addr(i_addr), .o_processor_strobe_n(i_processor_strobe_n),
    .o_controller_strobe_n(i_controller_strobe_n), .o_burst_step_n(i_burst_step_n),
    .o_global_write_n(i_global_write_n), .o_byte_write_gate_n(i_byte_write_gate_n),
    .o_byte_lane_select_n(i_byte_lane_select_n), .o_chip_select_a_n(i_chip_select_a_n),
    .o_chip_select_b(i_chip_select_b), .o_chip_select_c_n(i_chip_select_c_n),
    .o_output_drive_n(i_output_drive_n), .o_sleep_request(i_sleep_request),
    .o_burst_order(i_burst_order), .o_dq(h_dq));
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic g, b,
    input logic [LANES-1:0] l);
    host_u.put(1'b1, 1'b0, 1'b1, g, b, l, 1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    host_u.put(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b1, a, 32'h0);
  endtask : rd
  task automatic go(input logic v);
    host_u.put(1'b1, 1'b1, v, 1'b1, 1'b1, LANES_ALL, 1'b1, 17'h0, 32'h0);
  endtask : go
  // c low: deselect by strobe; c high: all strobes and selects inactive
  task automatic idle(input int n, input logic c = 1'b0);
    repeat (n) host_u.put(1'b1, c, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b0, 17'h0, 32'h0);
  endtask : idle
  task automatic t_words;
    chk("oe at reset", 32'h0, {31'h0, o_dq_oe});
    wr(17'h100, 32'h1111_1111, 1'b0, 1'b1, LANES_ALL);
    wr(17'h101, 32'h2222_2222, 1'b0, 1'b0, 4'he);
    wr(17'h102, 32'h3333_3333, 1'b1, 1'b0, LANES_NONE);
    idle(1);
    rd(17'h100);
    rd(17'h101);
    chk("read 0", 32'h1111_1111, o_dq);
    rd(17'h102);
    chk("read 1", 32'h2222_2222, o_dq);
    go(1'b1);
    chk("read 2", 32'h3333_3333, o_dq);
    chk("oe", 32'h1, {31'h0, o_dq_oe});
    idle(1);
  endtask : t_words
  task automatic t_lanes;
    logic [DATA_W-1:0] m;
    for (int i = 0; i < 16; i++)
    begin
      m = {{8{i[3]}}, {8{i[2]}}, {8{i[1]}}, {8{i[0]}}};
      wr(17'h200, 32'h0, 1'b0, 1'b1, LANES_ALL);
      wr(17'h200, 32'haabb_ccdd, 1'b1, 1'b0, i[3:0]);
      rd(17'h200);
      go(1'b1);
      chk("lanes", 32'haabb_ccdd & ~m, o_dq);
      idle(1);
    end
  endtask : t_lanes
  task automatic t_proc_write;
    wr(17'h300, 32'h5555_5555, 1'b0, 1'b1, LANES_ALL);
    // both strobes with global write: must be taken as a read only
    host_u.put(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, LANES_ALL, 1'b1, 17'h300, 32'h7777_7777);
    host_u.put(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, LANES_ALL, 1'b1, 17'h300, 32'h9999_9999);
    host_u.put(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'he, 1'b1, 17'h0, 32'h0000_00c3);
    rd(17'h300);
    go(1'b1);
    chk("proc write", 32'h5555_55c3, o_dq);
    idle(1);
  endtask : t_proc_write
  task automatic t_burst;
    logic [1:0] s, e;
    for (int i = 0; i < 4; i++)
      wr({15'h100, 2'(i)}, {30'h1234_5678, 2'(i)}, 1'b0, 1'b1, LANES_ALL);
    for (int o = 0; o < 2; o++)
    begin
      host_u.set(1'b0, o[0]);
      idle(3);
      for (int i = 0; i < 4; i++)
      begin
        s = 2'(i);
        rd({15'h100, s});
        for (int k = 0; k < 4; k++)
        begin
          go(k == 3);
          e = o[0] ? s ^ 2'(k) : s + 2'(k);
          chk("burst", {30'h1234_5678, e}, o_dq);
        end
      end
      idle(1);
    end
  endtask : t_burst
  task automatic t_sleep;
    idle(2);
    host_u.set(1'b1, 1'b1);
    idle(4, 1'b1);
    chk("asleep", 32'h1, {31'h0, o_sleep_active});
    wr(17'h100, 32'hdead_0000, 1'b0, 1'b1, LANES_ALL);
    host_u.set(1'b0, 1'b1);
    idle(4, 1'b1);
    chk("awake", 32'h0, {31'h0, o_sleep_active});
    rd(17'h100);
    go(1'b1);
    chk("kept", 32'h1111_1111, o_dq);
  endtask : t_sleep
  initial
  begin
    repeat (20) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    t_words();
    t_lanes();
    t_proc_write();
    t_burst();
    t_sleep();
    summarize();
  end
  initial
  begin
    repeat (50000) @(posedge i_clk);
    miscompares++;
    summarize();
  end
endmodule : pipelined_burst_sram_bench
bind pbs_sram pbs_sram_monitor mon_u (.*);
`default_nettype wire
